/* File: common/sarcv_consts.svh */
// Timing counts and field sizes for the converter control block
`ifndef SARCV_CONSTS_SVH
`define SARCV_CONSTS_SVH
`define SARCV_CLK_MHZ         250
`define SARCV_RESULT_BITS     16
`define SARCV_REINIT_US       20
`define SARCV_REINIT_CYC      (`SARCV_REINIT_US * `SARCV_CLK_MHZ)
`define SARCV_CONV_MAX_NS     527
`define SARCV_CONV_CYC        ((`SARCV_CONV_MAX_NS * `SARCV_CLK_MHZ) / 1000)
`define SARCV_FIFO_DEPTH      32
`endif

/* File: common/sarcv_pkg.sv */
// Types shared by the converter control block
package sarcv_pkg;
   typedef enum logic [1:0] {
      SARCV_INIT    = 2'h0,
      SARCV_ACQUIRE = 2'h1,
      SARCV_CONVERT = 2'h3
   } sarcv_state_t;
endpackage

/* File: hw/sarcv_fifo.sv */
// Result FIFO between conversion core and on-chip result stream
`timescale 1ns/100ps
`default_nettype none
module sarcv_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             clkEn,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
   logic             doWr, doRd;

   // Pointer one bit wider so full and empty stay distinct
   always_comb begin
      inReady    = (wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH);
      outValid   = wrPtr_reg != rdPtr_reg;
      outData    = mem[rdPtr_reg[AW-1:0]];
      doWr       = inValid && inReady && clkEn;
      doRd       = outValid && outReady && clkEn;
      wrPtr_next = doWr ? wrPtr_reg + 1'b1 : wrPtr_reg;
      rdPtr_next = doRd ? rdPtr_reg + 1'b1 : rdPtr_reg;
   end

   // Storage and pointers
   always_ff @(posedge clk) begin
      if (doWr) begin
         mem[wrPtr_reg[AW-1:0]] <= inData;
      end
      if (srst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
      end else begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
      end
   end
endmodule // sarcv_fifo
`default_nettype wire

/* File: hw/sarcv_ctrl.sv */
// Conversion sequencing and serial readout of a 16-bit SAR converter
// Operation
// - Power-on or supply drop holds logic in reset, then reinitialises.
// - Rising convert strobe starts a conversion and powers the core up; ignored here while the result FIFO is full.
// - Start requests during a conversion are ignored.
// - Busy is high throughout a conversion, low when done.
// - After conversion the core powers down and returns to acquisition.
// - Internal timer finishes each conversion within 527 ns.
// - Latest result stays readable while powered down.
// - Bits shift out only while enabled and the shift clock runs.
// - Output updates on each rising shift clock edge.
// - Top result bit holds until the first rising shift clock edge.
// - Normal mode: output released while read select high, driven when low.
// - Normal mode, select low: top bit appears as busy falls.
// - Shared output: one select low at a time, selected device drives.
// - Daisy mode: output always driven, select pin is serial input.
// - Results are 16-bit straight binary, most significant bit first.
`timescale 1ns/100ps
`default_nettype none
`include "sarcv_consts.svh"
module sarcv_ctrl #(
   parameter int RESULT_BITS = `SARCV_RESULT_BITS,
   parameter int REINIT_CYC  = `SARCV_REINIT_CYC,
   parameter int CONV_CYC    = `SARCV_CONV_CYC,
   parameter int FIFO_DEPTH  = `SARCV_FIFO_DEPTH
) (
   input  wire logic                   clk,
   input  wire logic                   srst,
   input  wire logic                   clkEn,
   input  wire logic                   supplyLow,
   input  wire logic                   convertStrobe,
   input  wire logic                   shiftClk,
   input  wire logic                   readSelectOrSerialIn,
   input  wire logic                   daisyMode,
   input  wire logic [RESULT_BITS-1:0] coreResult,
   output logic                        busy,
   output logic                        corePowerUp,
   output logic                        ready,
   output logic                        serialOut,
   output logic                        serialOutEn,
   output logic      [RESULT_BITS-1:0] lastResult,
   output logic      [RESULT_BITS-1:0] resultData,
   output logic                        resultValid,
   input  wire logic                   resultReady
);
   // One counter serves both periods, so it is sized for the longer one
   localparam int CW = $clog2(((REINIT_CYC > CONV_CYC) ? REINIT_CYC : CONV_CYC) + 1);

   // Two-flop synchronisers for pins from outside the clock domain
   logic [1:0] cnvSync_reg, sckSync_reg, selSync_reg, supSync_reg, modeSync_reg;
   logic       cnvPrev_reg, sckPrev_reg;
   logic       cnvRise, sckRise, inReset;

   always_ff @(posedge clk) begin
      if (srst) begin
         cnvSync_reg  <= 2'h0;
         sckSync_reg  <= 2'h0;
         selSync_reg  <= 2'h3;
         supSync_reg  <= 2'h3;
         modeSync_reg <= 2'h0;
         cnvPrev_reg  <= 1'b0;
         sckPrev_reg  <= 1'b0;
      end else if (clkEn) begin
         cnvSync_reg  <= {cnvSync_reg[0], convertStrobe};
         sckSync_reg  <= {sckSync_reg[0], shiftClk};
         selSync_reg  <= {selSync_reg[0], readSelectOrSerialIn};
         supSync_reg  <= {supSync_reg[0], supplyLow};
         modeSync_reg <= {modeSync_reg[0], daisyMode};
         cnvPrev_reg  <= cnvSync_reg[1];
         sckPrev_reg  <= sckSync_reg[1];
      end
   end

   // Edge detection only on second flop outputs
   always_comb begin
      cnvRise = cnvSync_reg[1] && !cnvPrev_reg;
      sckRise = sckSync_reg[1] && !sckPrev_reg;
      inReset = srst || supSync_reg[1];
   end

   // Conversion sequencer
   sarcv_pkg::sarcv_state_t state_reg, state_next;
   logic [CW-1:0]           count_reg, count_next;
   logic [RESULT_BITS-1:0]  shift_reg, shift_next;
   logic [RESULT_BITS-1:0]  result_reg, result_next;
   logic                    busy_reg, busy_next, pwr_reg, pwr_next, rdy_reg, rdy_next;
   logic                    push, fifoReady;
   logic                    sdo_reg, sdo_next, oe_reg, oe_next;

   always_comb begin
      state_next  = state_reg;
      count_next  = count_reg;
      busy_next   = busy_reg;
      pwr_next    = pwr_reg;
      rdy_next    = rdy_reg;
      result_next = result_reg;
      push        = 1'b0;
      unique case (state_reg)
         sarcv_pkg::SARCV_INIT: begin
            // Reinitialisation period; host must hold off starts
            if (count_reg == CW'(REINIT_CYC - 1)) begin
               state_next = sarcv_pkg::SARCV_ACQUIRE;
               count_next = '0;
               rdy_next   = 1'b1;
            end else begin
               count_next = count_reg + 1'b1;
            end
         end
         sarcv_pkg::SARCV_ACQUIRE: begin
            // New starts are ignored while the FIFO is full, so no result is dropped
            if (cnvRise && fifoReady) begin
               state_next = sarcv_pkg::SARCV_CONVERT;
               count_next = '0;
               busy_next  = 1'b1;
               pwr_next   = 1'b1;
            end
         end
         sarcv_pkg::SARCV_CONVERT: begin
            // Strobe edges ignored here
            if (count_reg == CW'(CONV_CYC - 1)) begin
               state_next  = sarcv_pkg::SARCV_ACQUIRE;
               busy_next   = 1'b0;
               pwr_next    = 1'b0;
               result_next = coreResult;
               push        = 1'b1;
            end else begin
               count_next = count_reg + 1'b1;
            end
         end
      endcase
   end

   // Output shift path; loaded in the same edge busy falls
   always_comb begin
      shift_next = shift_reg;
      if (push) begin
         shift_next = coreResult;
      end else if (sckRise && oe_reg) begin
         shift_next = {shift_reg[RESULT_BITS-2:0], modeSync_reg[1] ? selSync_reg[1] : 1'b0};
      end
      sdo_next = shift_next[RESULT_BITS-1];
      oe_next  = modeSync_reg[1] || !selSync_reg[1];
   end

   always_ff @(posedge clk) begin
      if (inReset) begin
         state_reg  <= sarcv_pkg::SARCV_INIT;
         count_reg  <= '0;
         busy_reg   <= 1'b0;
         pwr_reg    <= 1'b0;
         rdy_reg    <= 1'b0;
         result_reg <= '0;
         shift_reg  <= '0;
         sdo_reg    <= 1'b0;
         oe_reg     <= 1'b0;
      end else if (clkEn) begin
         state_reg  <= state_next;
         count_reg  <= count_next;
         busy_reg   <= busy_next;
         pwr_reg    <= pwr_next;
         rdy_reg    <= rdy_next;
         result_reg <= result_next;
         shift_reg  <= shift_next;
         sdo_reg    <= sdo_next;
         oe_reg     <= oe_next;
      end
   end

   // Result stream towards on-chip consumers
   logic [RESULT_BITS-1:0] fifoData;
   logic                   fifoValid;
   logic                   rv_reg;
   logic [RESULT_BITS-1:0] rd_reg;
   logic                   pop;

   sarcv_fifo #(
      .WIDTH (RESULT_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .srst     (inReset),
      .clkEn    (clkEn),
      .inData   (coreResult),
      .inValid  (push),
      .inReady  (fifoReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (pop)
   );

   // Registered output stage; pops when empty or being taken
   always_comb begin
      pop = fifoValid && (!rv_reg || resultReady);
   end

   always_ff @(posedge clk) begin
      if (inReset) begin
         rv_reg <= 1'b0;
         rd_reg <= '0;
      end else if (clkEn) begin
         if (pop) begin
            rv_reg <= 1'b1;
            rd_reg <= fifoData;
         end else if (resultReady) begin
            rv_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      busy        = busy_reg;
      corePowerUp = pwr_reg;
      ready       = rdy_reg;
      serialOut   = sdo_reg;
      serialOutEn = oe_reg;
      lastResult  = result_reg;
      resultValid = rv_reg;
      resultData  = rd_reg;
   end
endmodule // sarcv_ctrl
`default_nettype wire

/* File: testbench/sarcv_ctrl_monitor.sv */
// Checker for the converter control ports
`timescale 1ns/100ps
`default_nettype none
module sarcv_ctrl_monitor #(
   parameter int CONV_CYC = 131
) (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        shiftClk,
   input wire logic        readSelectOrSerialIn,
   input wire logic        daisyMode,
   input wire logic [15:0] coreResult,
   input wire logic        busy,
   input wire logic        corePowerUp,
   input wire logic        ready,
   input wire logic        serialOut,
   input wire logic        serialOutEn,
   input wire logic        resultValid,
   input wire logic        resultReady
);
   int busyCnt_reg;
   int busyCnt_next;
   // Busy cycles since the last rise; counter avoids a long repetition
   always_comb busyCnt_next = (srst || !busy) ? 0 : busyCnt_reg + 1;
   always_ff @(posedge clk) busyCnt_reg <= busyCnt_next;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_power_follows: assert property (corePowerUp == busy)
      else $error("power differs from busy");
   a_busy_length: assert property ($fell(busy) |-> busyCnt_reg == CONV_CYC)
      else $error("busy length wrong");
   a_reset_quiet: assert property ($fell(srst) |-> !busy && !ready && !resultValid)
      else $error("outputs active after reset");
   a_start_ready: assert property ($rose(busy) |-> ready)
      else $error("start before ready");
   a_top_bit: assert property ($fell(busy) |-> serialOut == $past(coreResult[15]))
      else $error("top bit not loaded");
   a_select_high: assert property ((!daisyMode && readSelectOrSerialIn) [*5] |-> !serialOutEn)
      else $error("driven while deselected");
   a_daisy_drive: assert property ((ready && (daisyMode || !readSelectOrSerialIn)) [*5] |-> serialOutEn)
      else $error("output not driven");
   a_idle_hold: assert property ((ready && !busy && !shiftClk && $stable(daisyMode)) [*6] |-> $stable(serialOut))
      else $error("output moved while idle");
   c_done: cover property ($fell(busy));
   c_drain: cover property (resultValid && resultReady);
   c_daisy: cover property (daisyMode && $rose(shiftClk));
endmodule // sarcv_ctrl_monitor
`default_nettype wire

/* File: testbench/sarcv_host_model.sv */
// Host serial master: shift clock frames and upstream serial data
`timescale 1ns/100ps
`default_nettype none
module sarcv_host_model (
   output logic      shiftClk,
   output logic      serialIn,
   input  wire logic serialOut
);
   // Clock stands low between frames to save power
   initial begin
      shiftClk = 1'b0;
      serialIn = 1'b0;
   end
   // One 16-bit frame at 80 ns; bits taken just before each rise
   task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
      #1.3;
      for (int i = 15; i >= 0; i--) begin
         serialIn = tx[i];
         #40; // (slow bench clock; throughput not measured here)
         rx[i] = serialOut;
         shiftClk = 1'b1;
         #40;
         shiftClk = 1'b0;
      end
   endtask
endmodule // sarcv_host_model
`default_nettype wire

/* File: testbench/sarcv_ctrl_tb_top.sv */
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module sarcv_ctrl_tb_top;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        clkEn = 1'b1;
   logic        supplyLow = 1'b0;
   logic        convertStrobe = 1'b0;
   logic        readSelN = 1'b1;
   logic        daisyMode = 1'b0;
   logic        resultReady = 1'b0;
   logic [15:0] coreResult = 16'h0000;
   logic [15:0] lastResult, resultData, a, b, rx;
   logic        shiftClk, serialIn, busy, corePowerUp, ready, serialOut, serialOutEn, resultValid;
   logic [15:0] expQ[$];
   int          nMismatch = 0;
   int          nTests = 0;
   int          cyc = 0;
   int          seed = 32'h374C;
   wire logic   readSelectOrSerialIn = daisyMode ? serialIn : readSelN;
   // Clock, 4 ns period
   always #2 clk = ~clk;
   sarcv_ctrl #(.REINIT_CYC(20)) dut_u (
      .clk                  (clk),
      .srst                 (srst),
      .clkEn                (clkEn),
      .supplyLow            (supplyLow),
      .convertStrobe        (convertStrobe),
      .shiftClk             (shiftClk),
      .readSelectOrSerialIn (readSelectOrSerialIn),
      .daisyMode            (daisyMode),
      .coreResult           (coreResult),
      .busy                 (busy),
      .corePowerUp          (corePowerUp),
      .ready                (ready),
      .serialOut            (serialOut),
      .serialOutEn          (serialOutEn),
      .lastResult           (lastResult),
      .resultData           (resultData),
      .resultValid          (resultValid),
      .resultReady          (resultReady)
   );
   sarcv_host_model host_u (
      .shiftClk  (shiftClk),
      .serialIn  (serialIn),
      .serialOut (serialOut)
   );
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      nTests++;
      if (seen !== exp) begin
         nMismatch++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tallyAndFinish();
      $display("Mismatches %0d of %0d checks", nMismatch, nTests);
      if (nMismatch == 0 && nTests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // One conversion with a second strobe edge inside the first 40 ns
   task automatic conv(input logic take, output logic [15:0] v);
      v = 16'($random(seed));
      coreResult = v;
      convertStrobe = 1'b1;
      repeat (8) @(negedge clk);
      convertStrobe = 1'b0;
      @(negedge clk);
      convertStrobe = 1'b1;
      check({15'h0, busy}, {15'h0, take});
      if (take) expQ.push_back(v);
      repeat (140) @(negedge clk);
      check({15'h0, busy}, 16'h0000);
      if (take) check({15'h0, serialOut}, {15'h0, v[15]});
      convertStrobe = 1'b0;
      repeat (120) @(negedge clk);
   endtask
   // Accepted results against the oldest note; looked at mid-cycle, before the taking edge
   always @(negedge clk) begin
      #1;
      if (resultValid === 1'b1 && resultReady === 1'b1) check(resultData, expQ.size() > 0 ? expQ.pop_front() : 16'hXXXX);
   end
   // Run ceiling, well above the expected run of about 11000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         nMismatch++;
         tallyAndFinish();
      end
   end
   initial begin
      repeat (3) @(negedge clk);
      srst = 1'b0;
      conv(1'b0, a);
      check({15'h0, ready}, 16'h0001);
      wait (ready === 1'b1);
      readSelN = 1'b0;
      // FIFO of 32 plus the output register hold 33 results
      repeat (33) conv(1'b1, a);
      conv(1'b0, b);
      check(lastResult, a);
      host_u.frame(16'h0000, rx);
      check(rx, a);
      @(negedge clk);
      readSelN = 1'b1;
      repeat (6) @(negedge clk);
      check({15'h0, serialOutEn}, 16'h0000);
      // Drain with the reader stalling at random
      repeat (300) begin
         @(negedge clk);
         resultReady = 1'($random(seed));
      end
      resultReady = 1'b1;
      repeat (20) @(negedge clk);
      check(16'(expQ.size()), 16'h0000);
      daisyMode = 1'b1;
      conv(1'b1, a);
      check({15'h0, serialOutEn}, 16'h0001);
      b = 16'($random(seed));
      host_u.frame(b, rx);
      check(rx, a);
      host_u.frame(16'h0000, rx);
      check(rx, b);
      @(negedge clk);
      supplyLow = 1'b1;
      repeat (4) @(negedge clk);
      supplyLow = 1'b0;
      repeat (4) @(negedge clk);
      check({15'h0, ready}, 16'h0000);
      repeat (40) @(negedge clk);
      check({15'h0, ready}, 16'h0001);
      tallyAndFinish();
   end
endmodule // sarcv_ctrl_tb_top
bind sarcv_ctrl sarcv_ctrl_monitor #(.CONV_CYC(CONV_CYC)) mon_u (
   .clk                  (clk),
   .srst                 (srst),
   .shiftClk             (shiftClk),
   .readSelectOrSerialIn (readSelectOrSerialIn),
   .daisyMode            (daisyMode),
   .coreResult           (coreResult),
   .busy                 (busy),
   .corePowerUp          (corePowerUp),
   .ready                (ready),
   .serialOut            (serialOut),
   .serialOutEn          (serialOutEn),
   .resultValid          (resultValid),
   .resultReady          (resultReady)
);
`default_nettype wire
